// file: wave_run_pkg.sv
// constants for the standard waveform run control block
// assumes one 10 MHz clock and a plain word-wide register port
// ======================================================
package wave_run_pkg;
    // ======================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_LOOPS = 8'h04;
    localparam logic [7:0] OFF_RAMP = 8'h08;
    localparam logic [7:0] OFF_SHAPE = 8'h0C;
    localparam logic [7:0] OFF_FREQ = 8'h10;
    localparam logic [7:0] OFF_LEVEL = 8'h14;
    localparam logic [7:0] OFF_CMD = 8'h18;
    localparam logic [7:0] OFF_STAT = 8'h1C;
    localparam logic [7:0] OFF_NOISE = 8'h20;
    // ======================================================
    // control field positions
    localparam int MODE_LSB = 0;
    localparam int ARM_BIT = 2;
    localparam int IDLE_BIT = 3;
    localparam int ENSRC_LSB = 4;
    localparam int INSRC_LSB = 6;
    localparam int NOISE_BIT = 8;
    localparam int CMD_EN_BIT = 0;
    localparam int CMD_INIT_BIT = 1;
    localparam int CMD_ABORT_BIT = 2;
    // ======================================================
    // reset values and limits
    localparam logic [8:0] CTRL_RST = 9'h000;
    localparam logic [19:0] LOOPS_RST = 20'h00001;
    localparam logic [19:0] LOOPS_MAX = 20'hF4240;
    localparam logic [7:0] SINC_RST = 8'h04;
    localparam logic [8:0] PCT_FULL = 9'h064;
    localparam logic [6:0] PCT_LAST = 7'h63;
    localparam logic [15:0] DIV_RST = 16'h000A;
    localparam logic [7:0] BW_RST = 8'h01;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    // ======================================================
    // timing
    localparam int CLK_NS = 100;
    localparam int RECOMP_NS = 100000;
    localparam int RECOMP_CYC = (RECOMP_NS + CLK_NS - 1) / CLK_NS;
    // ======================================================
    // enumerations
    typedef enum logic [1:0] {RUN_CONT = 2'b00, RUN_TRIG = 2'b01, RUN_GATE = 2'b10} run_mode_t;
    typedef enum logic [1:0] {ENA_BUS = 2'b00, ENA_EVENT = 2'b01, ENA_TRIG = 2'b10} ena_src_t;
    typedef enum logic [1:0] {INI_FP = 2'b00, INI_BUS = 2'b01, INI_TRIG = 2'b10,
        INI_EVENT = 2'b11} ini_src_t;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01} run_state_t;
    typedef enum logic [1:0] {SEG_DELAY = 2'b00, SEG_RISE = 2'b01, SEG_FALL = 2'b10,
        SEG_HOLD = 2'b11} ramp_seg_t;
endpackage : wave_run_pkg

// file: edge_det.sv
// registered edge finder for a group of synchronous inputs
// assumes inputs are already synchronous to clk
`timescale 1ns/1ns
module edge_det
    import wave_run_pkg::*;
#(
    parameter int W = 4
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] rise_q,
    output logic [W-1:0] any_q
);
    logic [W-1:0] last_q;
    wire [W-1:0] rise_d = din & ~last_q;
    wire [W-1:0] any_d = din ^ last_q;

    if (W < 1) begin : g_chk
        $error("edge_det width must be at least one");
    end

    // one pulse per edge, a held level gives no more
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            last_q <= '0;
            rise_q <= '0;
            any_q <= '0;
        end
        else
        begin
            last_q <= din;
            rise_q <= rise_d;
            any_q <= any_d;
        end
    end

    for (genvar i = 0; i < W; i++) begin : g_a
        single_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
            rise_q[i] |=> !rise_q[i])
            else $error("edge pulse longer than one cycle");
    end
endmodule : edge_det

// file: noise_mem.sv
// small noise sample store with registered read port
// assumes one writer and one reader on the same clock
`timescale 1ns/1ns
module noise_mem
    import wave_run_pkg::*;
#(
    parameter int W = 16,
    parameter int D = 256
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [$clog2(D)-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [$clog2(D)-1:0] raddr,
    output logic [W-1:0] rdata_q
);
    logic [W-1:0] mem [D];

    if (D < 2 || W < 1) begin : g_chk
        $error("noise_mem needs depth of two or more");
    end

    // write port
    always_ff @(posedge clk)
    begin
        if (wr_en)
            mem[waddr] <= wdata;
    end

    // read data out of a register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_q <= '0;
        else
            rdata_q <= mem[raddr];
    end
endmodule : noise_mem

// file: wave_run_ctrl.sv
// run control for the standard waveform generator
// assumes synchronous trigger, event, gate and panel inputs
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module wave_run_ctrl
    import wave_run_pkg::*;
#(
    parameter int NOISE_DEPTH = 256,
    parameter int NOISE_W = 16
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata_q,
    input wire logic trig_in,
    input wire logic event_in,
    input wire logic gate_in,
    input wire logic fp_init,
    input wire logic fp_abort,
    output logic run_q,
    output logic idle_dc_q,
    output logic [6:0] pct_q,
    output logic [1:0] ramp_seg_q,
    output logic [6:0] seg_pos_q,
    output logic invert_q,
    output logic settled_q,
    output logic [NOISE_W-1:0] noise_q,
    output logic [15:0] amp_q,
    output logic [15:0] offset_q,
    output logic [7:0] sinc_cyc_q,
    output logic fp_lock_q
);
    localparam int AW = $clog2(NOISE_DEPTH);

    if (NOISE_DEPTH < 2 || NOISE_W < 1 || NOISE_W > 16) begin : g_chk
        $error("noise buffer size not supported");
    end

    // ======================================================
    // registers
    logic [8:0] ctrl_q;
    logic [19:0] loops_q;
    logic [19:0] loop_cnt_q;
    logic [6:0] delay_q, rise_q, fall_q;
    logic ramp_rej_q;
    logic signed [7:0] expo_q;
    logic [15:0] div_q;
    logic [15:0] sub_q;
    logic [7:0] bw_q;
    logic [7:0] bw_cnt_q;
    logic [$clog2(RECOMP_CYC+1)-1:0] recomp_q;
    logic enabled_q;
    logic halt_q;
    run_state_t state_q;
    logic fill_q;
    logic [AW-1:0] waddr_q, raddr_q;
    logic [15:0] lfsr_q;
    logic [3:0] rise_e, any_e;
    logic [NOISE_W-1:0] noise_rd;

    // ======================================================
    // register port decode
    wire wr_ctrl = wr_en && addr == OFF_CTRL;
    wire wr_loops = wr_en && addr == OFF_LOOPS;
    wire wr_ramp = wr_en && addr == OFF_RAMP;
    wire wr_shape = wr_en && addr == OFF_SHAPE;
    wire wr_freq = wr_en && addr == OFF_FREQ;
    wire wr_level = wr_en && addr == OFF_LEVEL;
    wire wr_cmd = wr_en && addr == OFF_CMD;
    wire wr_noise = wr_en && addr == OFF_NOISE;
    wire [8:0] pct_sum = {2'b00, wdata[6:0]} + {2'b00, wdata[14:8]} + {2'b00, wdata[22:16]};
    wire ramp_ok = pct_sum <= PCT_FULL;
    wire [19:0] loops_in = wdata[19:0];

    // ======================================================
    // control fields
    wire [1:0] run_mode = ctrl_q[MODE_LSB +: 2];
    wire self_arm = !ctrl_q[ARM_BIT];
    wire idle_dc = !ctrl_q[IDLE_BIT];
    wire [1:0] en_src = ctrl_q[ENSRC_LSB +: 2];
    wire [1:0] in_src = ctrl_q[INSRC_LSB +: 2];
    wire noise_on = ctrl_q[NOISE_BIT];

    // ======================================================
    // event sources
    wire trig_r = rise_e[0];
    wire event_t = any_e[1];
    wire fp_init_r = rise_e[2] && !fp_lock_q;
    wire fp_abort_r = rise_e[3] && !fp_lock_q;
    wire bus_en_p = wr_cmd && wdata[CMD_EN_BIT];
    wire bus_init_p = wr_cmd && wdata[CMD_INIT_BIT];
    wire bus_abort_p = wr_cmd && wdata[CMD_ABORT_BIT];
    wire enable_ev = !self_arm && (
        (en_src == ENA_BUS && bus_en_p) ||
        (en_src == ENA_EVENT && event_t) ||
        (en_src == ENA_TRIG && trig_r));
    wire init_ev = run_mode != RUN_CONT && (
        (in_src == INI_FP && fp_init_r) ||
        (in_src == INI_BUS && bus_init_p) ||
        (in_src == INI_TRIG && trig_r) ||
        (in_src == INI_EVENT && event_t));
    wire abort_ev = fp_abort_r || (bus_abort_p && !self_arm);
    wire go = (self_arm || enabled_q) && !halt_q;

    edge_det #(
        .W(4)
    ) u_edge (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({fp_abort, fp_init, event_in, trig_in}),
        .rise_q(rise_e),
        .any_q(any_e)
    );

    // ======================================================
    // phase and sequencing
    wire phase_on = state_q == ST_RUN || !idle_dc;
    wire sub_last = sub_q == div_q - 16'h0001;
    wire wave_end = phase_on && sub_last && pct_q == PCT_LAST;
    wire start = state_q == ST_IDLE && go && !abort_ev && (
        run_mode == RUN_CONT ||
        (run_mode == RUN_TRIG && init_ev) ||
        (run_mode == RUN_GATE && gate_in));
    wire loop_done = run_mode == RUN_TRIG && wave_end && loop_cnt_q == 20'h00001;
    wire stop = state_q == ST_RUN && (abort_ev || !go || loop_done ||
        (run_mode == RUN_GATE && !gate_in));

    // ramp segment boundaries in percent
    wire [8:0] b_rise = {2'b00, delay_q};
    wire [8:0] b_fall = b_rise + {2'b00, rise_q};
    wire [8:0] b_hold = b_fall + {2'b00, fall_q};
    wire [8:0] pct_w = {2'b00, pct_q};
    wire [8:0] pos_rise = pct_w - b_rise;
    wire [8:0] pos_fall = pct_w - b_fall;
    wire [1:0] seg_d = pct_w < b_rise ? SEG_DELAY : pct_w < b_fall ? SEG_RISE :
        pct_w < b_hold ? SEG_FALL : SEG_HOLD;
    wire [6:0] pos_d = seg_d == SEG_DELAY ? pct_q : seg_d == SEG_RISE ? pos_rise[6:0] :
        seg_d == SEG_FALL ? pos_fall[6:0] : 7'h00;

    // read mux
    wire [31:0] stat_w = {24'h000000, state_q, fill_q, fp_lock_q, halt_q, enabled_q,
        ramp_rej_q, settled_q};
    wire [31:0] rd_mux =
        addr == OFF_CTRL ? {23'h000000, ctrl_q} :
        addr == OFF_LOOPS ? {12'h000, loops_q} :
        addr == OFF_RAMP ? {9'h000, fall_q, 1'b0, rise_q, 1'b0, delay_q} :
        addr == OFF_SHAPE ? {16'h0000, expo_q, sinc_cyc_q} :
        addr == OFF_FREQ ? {16'h0000, div_q} :
        addr == OFF_LEVEL ? {offset_q, amp_q} :
        addr == OFF_STAT ? stat_w :
        addr == OFF_NOISE ? {24'h000000, bw_q} : 32'h00000000;

    // settings written by software
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_q <= CTRL_RST;
            loops_q <= LOOPS_RST;
            delay_q <= 7'h00;
            rise_q <= 7'h32;
            fall_q <= 7'h32;
            ramp_rej_q <= 1'b0;
            sinc_cyc_q <= SINC_RST;
            expo_q <= 8'sh01;
            div_q <= DIV_RST;
            amp_q <= 16'h0000;
            offset_q <= 16'h0000;
            bw_q <= BW_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= wdata[8:0];
            if (wr_loops)
                loops_q <= loops_in == 20'h00000 ? LOOPS_RST :
                    loops_in > LOOPS_MAX ? LOOPS_MAX : loops_in;
            if (wr_ramp && ramp_ok)
            begin
                delay_q <= wdata[6:0];
                rise_q <= wdata[14:8];
                fall_q <= wdata[22:16];
            end
            if (wr_ramp)
                ramp_rej_q <= !ramp_ok;
            if (wr_shape)
            begin
                sinc_cyc_q <= wdata[7:0];
                expo_q <= wdata[15:8];
            end
            if (wr_freq && wdata[15:0] != 16'h0000)
                div_q <= wdata[15:0];
            if (wr_level)
            begin
                amp_q <= wdata[15:0];
                offset_q <= wdata[31:16];
            end
            if (wr_noise && wdata[7:0] != 8'h00)
                bw_q <= wdata[7:0];
        end
    end

    // recompute timer, read data, derived flags
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            recomp_q <= '0;
            settled_q <= 1'b1;
            rdata_q <= 32'h00000000;
            invert_q <= 1'b0;
            fp_lock_q <= 1'b0;
        end
        else
        begin
            if (wr_shape || wr_freq)
                recomp_q <= ($clog2(RECOMP_CYC+1))'(RECOMP_CYC);
            else if (recomp_q != '0)
                recomp_q <= recomp_q - 1'b1;
            settled_q <= !(wr_shape || wr_freq) && recomp_q <= 1;
            rdata_q <= rd_en ? rd_mux : 32'h00000000;
            invert_q <= expo_q < 0;
            fp_lock_q <= in_src == INI_BUS;
        end
    end

    // arming, halt and run state
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            enabled_q <= 1'b0;
            halt_q <= 1'b0;
            state_q <= ST_IDLE;
            run_q <= 1'b0;
            loop_cnt_q <= LOOPS_RST;
        end
        else
        begin
            if (enable_ev)
                enabled_q <= 1'b1;
            else if (abort_ev || self_arm)
                enabled_q <= 1'b0;
            if (abort_ev)
                halt_q <= 1'b1;
            else if (enable_ev || init_ev || wr_ctrl)
                halt_q <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= ST_RUN;
                        run_q <= 1'b1;
                        loop_cnt_q <= loops_q;
                    end
                end
                ST_RUN:
                begin
                    if (stop)
                    begin
                        state_q <= ST_IDLE;
                        run_q <= 1'b0;
                    end
                    else if (wave_end && run_mode == RUN_TRIG)
                        loop_cnt_q <= loop_cnt_q - 20'h00001;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    run_q <= 1'b0;
                end
            endcase
        end
    end

    // waveform phase: samples within a percent, percent within a period
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sub_q <= 16'h0000;
            pct_q <= 7'h00;
            ramp_seg_q <= SEG_DELAY;
            seg_pos_q <= 7'h00;
            idle_dc_q <= 1'b1;
        end
        else
        begin
            if (!phase_on || start || stop)
            begin
                sub_q <= 16'h0000;
                pct_q <= 7'h00;
            end
            else if (sub_last)
            begin
                sub_q <= 16'h0000;
                pct_q <= pct_q == PCT_LAST ? 7'h00 : pct_q + 7'h01;
            end
            else
                sub_q <= sub_q + 16'h0001;
            ramp_seg_q <= seg_d;
            seg_pos_q <= pos_d;
            idle_dc_q <= state_q != ST_RUN && idle_dc;
        end
    end

    // ======================================================
    // noise buffer: filled once when switched on, then replayed
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fill_q <= 1'b0;
            waddr_q <= '0;
            raddr_q <= '0;
            lfsr_q <= LFSR_SEED;
            bw_cnt_q <= 8'h00;
        end
        else
        begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            if (wr_ctrl && wdata[NOISE_BIT] && !noise_on)
            begin
                fill_q <= 1'b1;
                waddr_q <= '0;
            end
            else if (fill_q)
            begin
                waddr_q <= waddr_q + 1'b1;
                fill_q <= waddr_q != AW'(NOISE_DEPTH - 1);
            end
            if (!noise_on || fill_q)
            begin
                raddr_q <= '0;
                bw_cnt_q <= 8'h00;
            end
            else if (bw_cnt_q >= bw_q - 8'h01)
            begin
                bw_cnt_q <= 8'h00;
                raddr_q <= raddr_q == AW'(NOISE_DEPTH - 1) ? '0 : raddr_q + 1'b1;
            end
            else
                bw_cnt_q <= bw_cnt_q + 8'h01;
        end
    end

    assign noise_q = noise_rd;

    noise_mem #(
        .W(NOISE_W),
        .D(NOISE_DEPTH)
    ) u_noise (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(fill_q),
        .waddr(waddr_q),
        .wdata(lfsr_q[NOISE_W-1:0]),
        .raddr(raddr_q),
        .rdata_q(noise_rd)
    );

    // ======================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_run_wave_end;
        state_q == ST_RUN && run_mode == RUN_TRIG && wave_end;
    endsequence

    abort_stops_run_a: assert property (abort_ev |=> state_q == ST_IDLE && !run_q)
        else $error("abort did not stop output");
    bus_abort_self_a: assert property (
        bus_abort_p && self_arm && !fp_abort_r && !halt_q |=> !halt_q)
        else $error("bus abort acted in self-armed mode");
    ramp_reject_a: assert property (
        wr_ramp && !ramp_ok |=> ramp_rej_q && $stable(delay_q) && $stable(rise_q))
        else $error("oversized ramp setting taken");
    recompute_hold_a: assert property (
        wr_shape |=> !settled_q [*8])
        else $error("settled too soon after shape change");
    cont_keeps_run_a: assert property (
        state_q == ST_RUN && run_mode == RUN_CONT && go && !abort_ev |=> run_q)
        else $error("continuous run interrupted");
    trig_waits_a: assert property (
        state_q == ST_IDLE && run_mode == RUN_TRIG && !init_ev && !wr_ctrl |=> !run_q)
        else $error("triggered mode ran without initiation");
    last_loop_idle_a: assert property (
        s_run_wave_end ##0 (loop_cnt_q == 20'h00001) |=> state_q == ST_IDLE)
        else $error("run continued past last loop");
    gate_drop_a: assert property (
        state_q == ST_RUN && run_mode == RUN_GATE && !gate_in |=> !run_q)
        else $error("output ran with gate low");
    ramp_hold_a: assert property (
        pct_w >= b_hold && phase_on |=> ramp_seg_q == SEG_HOLD)
        else $error("ramp not held after fall");
endmodule : wave_run_ctrl

// file: far_side_model.sv
// trigger, event, gate and front-panel lines seen from outside the block
// assumes one clock; lines change by non-blocking assignment after an edge
`timescale 1ns/1ns
module far_side_model
(
    input wire logic clk,
    output logic trig_in,
    output logic event_in,
    output logic gate_in,
    output logic fp_init,
    output logic fp_abort
);
    // bit 0 trigger, 1 event, 2 gate, 3 panel initiate, 4 panel abort
    logic [4:0] lines_q = 5'h00;
    assign {fp_abort, fp_init, gate_in, event_in, trig_in} = lines_q;
    // set one line just after an edge and hold it there
    task automatic drive(input int idx, input logic lvl);
        @(posedge clk);
        lines_q[idx] <= lvl;
    endtask : drive
endmodule : far_side_model

// file: standard_waveform_run_control_test.sv
// self-checking bench for the run control block
// assumes far_side_model drives the trigger, event, gate and panel lines
`timescale 1ns/1ns
module standard_waveform_run_control_test;
    import wave_run_pkg::*;
    logic clk = 0, sys_rst = 1, wr_en = 0, rd_en = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata_q, v;
    logic trig_in, event_in, gate_in, fp_init, fp_abort, run_q, idle_dc_q;
    logic invert_q, settled_q, fp_lock_q;
    logic [6:0] pct_q, seg_pos_q;
    logic [1:0] ramp_seg_q;
    logic [7:0] sinc_cyc_q;
    logic [15:0] noise_q, amp_q, offset_q;
    int errors = 0, check_count = 0, n, pp;
    logic [31:0] nq [$];
    // register model and write masks, one word each
    logic [31:0] mdl [9] = '{32'h0, 32'h1, 32'h323200, 32'h104, 32'hA, 32'h0, 32'h0,
        32'h0, 32'h1};
    logic [31:0] msk [9] = '{32'h1FF, 32'hFFFFF, 32'h7F7F7F, 32'hFFFF, 32'hFFFF,
        32'hFFFFFFFF, 32'h0, 32'h0, 32'hFF};
    always #50 clk = ~clk;
    wave_run_ctrl #(.NOISE_DEPTH(8)) wave_run_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
        .trig_in(trig_in), .event_in(event_in), .gate_in(gate_in), .fp_init(fp_init),
        .fp_abort(fp_abort), .run_q(run_q), .idle_dc_q(idle_dc_q), .pct_q(pct_q),
        .ramp_seg_q(ramp_seg_q), .seg_pos_q(seg_pos_q), .invert_q(invert_q),
        .settled_q(settled_q), .noise_q(noise_q), .amp_q(amp_q), .offset_q(offset_q),
        .sinc_cyc_q(sinc_cyc_q), .fp_lock_q(fp_lock_q));
    far_side_model far_side_model_inst (.clk(clk), .trig_in(trig_in),
        .event_in(event_in), .gate_in(gate_in), .fp_init(fp_init), .fp_abort(fp_abort));
    // ======================================================
    // compare and report
    task automatic complete_run();
        $display("errors %0d check_count %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t pin got %h exp %h", $time, got, exp);
        end
    endtask : chk_pin
    // ======================================================
    // register port and model
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        r = d;
        if (a == OFF_RAMP && int'(d[6:0]) + int'(d[14:8]) + int'(d[22:16]) > 100)
            r = mdl[2];
        if (a == OFF_LOOPS)
            r = (d[19:0] == 0) ? 32'h1 : (d[19:0] > LOOPS_MAX) ? 32'(LOOPS_MAX) : d;
        mdl[a >> 2] = r & msk[a >> 2];
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata_q;
    endtask : rd
    task automatic rchk(input logic [7:0] a);
        rd(a);
        chk_word(v, mdl[a >> 2]);
    endtask : rchk
    task automatic wait_run(input logic lvl);
        n = 0;
        while (run_q !== lvl && n < 3000)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk_pin(run_q, lvl);
        if (n == 3000)
            complete_run();
    endtask : wait_run
    function automatic logic [1:0] segx(input int p);
        int d, r;
        d = mdl[2][6:0];
        r = mdl[2][14:8];
        return p < d ? 2'h0 : p < d + r ? 2'h1 : p < d + r + mdl[2][22:16] ? 2'h2 : 2'h3;
    endfunction : segx
    // expected position inside the segment that percent p falls in
    function automatic logic [6:0] posx(input int p);
        int d, r;
        d = mdl[2][6:0];
        r = mdl[2][14:8];
        return p < d ? 7'(p) : p < d + r ? 7'(p - d) :
            p < d + r + mdl[2][22:16] ? 7'(p - d - r) : 7'h00;
    endfunction : posx
    // ======================================================
    // main sequence
    initial
    begin
        v = $urandom(56174);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 chk_pin(sinc_cyc_q, 16'h4);
        for (int i = 0; i < 9; i++)
            if (i < 6 || i == 8) rchk(8'(i * 4));
        rd(8'h24);
        chk_word(v, 32'h0);
        chk_pin(run_q, 1'b1);
        wr(OFF_CMD, 32'h4);
        repeat (3) @(posedge clk);
        #1 chk_pin(run_q, 1'b1);
        far_side_model_inst.drive(4, 1'b1);
        far_side_model_inst.drive(4, 1'b0);
        wait_run(1'b0);
        wr(OFF_RAMP, 32'h1E2828);
        rchk(OFF_RAMP);
        rd(OFF_STAT);
        chk_word(v & 32'h2, 32'h2);
        wr(OFF_RAMP, {8'h0, 8'($urandom % 33), 8'($urandom % 34), 8'($urandom % 34)});
        rchk(OFF_RAMP);
        wr(OFF_LEVEL, $urandom);
        chk_pin(amp_q, mdl[5][15:0]);
        chk_pin(offset_q, mdl[5][31:16]);
        wr(OFF_FREQ, 32'h1);
        wr(OFF_SHAPE, 32'hF807);
        @(posedge clk);
        #1 chk_pin(settled_q, 1'b0);
        chk_pin(invert_q, 1'b1);
        chk_pin(sinc_cyc_q, 16'h7);
        repeat (RECOMP_CYC + 5) @(posedge clk);
        #1 chk_pin(settled_q, 1'b1);
        wr(OFF_LOOPS, 32'h0);
        rchk(OFF_LOOPS);
        wr(OFF_LOOPS, 32'hFFFFF);
        rchk(OFF_LOOPS);
        wr(OFF_LOOPS, 32'h2);
        wr(OFF_CTRL, 32'h81);
        wait_run(1'b0);
        chk_pin(idle_dc_q, 1'b1);
        far_side_model_inst.drive(0, 1'b1);
        wait_run(1'b1);
        // segment outputs are registered from the percent of the cycle before
        pp = 0;
        for (n = 1; n < 1000 && run_q === 1'b1; n++)
        begin
            chk_pin(ramp_seg_q, segx(pp));
            chk_pin(seg_pos_q, posx(pp));
            pp = pct_q;
            @(posedge clk);
            #1;
        end
        chk_pin(16'(n - 1), 16'h00C8);
        repeat (20) @(posedge clk);
        #1 chk_pin(run_q, 1'b0);
        far_side_model_inst.drive(0, 1'b0);
        wr(OFF_CTRL, 32'h2);
        far_side_model_inst.drive(2, 1'b1);
        wait_run(1'b1);
        far_side_model_inst.drive(2, 1'b0);
        wait_run(1'b0);
        wr(OFF_CTRL, 32'h41);
        @(posedge clk);
        #1 chk_pin(fp_lock_q, 1'b1);
        wr(OFF_CMD, 32'h2);
        wait_run(1'b1);
        far_side_model_inst.drive(4, 1'b1);
        repeat (5) @(posedge clk);
        #1 chk_pin(run_q, 1'b1);
        far_side_model_inst.drive(4, 1'b0);
        wait_run(1'b0);
        wr(OFF_CTRL, 32'h14);
        repeat (3) @(posedge clk);
        #1 chk_pin(run_q, 1'b0);
        far_side_model_inst.drive(1, 1'b1);
        wait_run(1'b1);
        // triggered with idle wave, started from the panel
        wr(OFF_CTRL, 32'h9);
        wait_run(1'b0);
        chk_pin(idle_dc_q, 1'b0);
        far_side_model_inst.drive(3, 1'b1);
        wait_run(1'b1);
        far_side_model_inst.drive(3, 1'b0);
        wait_run(1'b0);
        wr(OFF_NOISE, 32'h2);
        wr(OFF_CTRL, 32'h100);
        repeat (20) @(posedge clk);
        repeat (32)
        begin
            @(posedge clk);
            #1 nq.push_back(noise_q);
        end
        for (int i = 0; i < 16; i++)
            chk_pin(nq[i + 16], nq[i]);
        // a two-cycle sample rate gives a new value on every second sample
        pp = 0;
        for (int i = 0; i < 16; i++)
            if (nq[i + 1] !== nq[i])
                pp++;
        chk_pin(16'(pp), 16'h0008);
        complete_run();
    end
endmodule : standard_waveform_run_control_test
